// >>> rtl/ca_defines.svh
`ifndef CA_DEFINES_SVH
`define CA_DEFINES_SVH
// register byte offsets on the bus
`define CA_OFS_CTRL 8'h00
`define CA_OFS_CFG 8'h04
`define CA_OFS_CNT_LO 8'h08
`define CA_OFS_CNT_HI 8'h0c
`define CA_OFS_MODE 8'h10
`define CA_OFS_CMP_LO 8'h30
`define CA_OFS_CMP_HI 8'h50
// control/flags register fields
`define CA_BIT_OVF 7
`define CA_BIT_RUN 6
// mode config register fields
`define CA_BIT_IDLE 7
`define CA_BIT_WDOG 6
`define CA_BIT_OVF_IE 0
// module mode register fields
`define CA_BIT_MOD_IE 0
`define CA_BIT_PWM 1
`define CA_BIT_TOGGLE 2
`define CA_BIT_FLAG_MATCH 3
`define CA_BIT_CAP_FALL 4
`define CA_BIT_CAP_RISE 5
`define CA_BIT_CMP_EN 6
// reset values and timebase
`define CA_RST_BYTE 8'h00
`define CA_RST_CNT 16'h0000
`define CA_TICK_DIV 8'h02
`define CA_MODULES 5
`define CA_WDOG_MODULE 4
`endif

// >>> rtl/ca_pkg.sv
package ca_pkg;
	typedef logic [4:0][7:0] ca_bytes_type;
	// complete state of the counter array
	typedef struct packed {
		logic ovf_flag; // counter overflow flag
		logic run; // run control
		logic [4:0] ev_flag; // module event flags
		logic idle_stop; // halt while cpu idles
		logic wdog_en; // watchdog enable
		logic ovf_ie; // overflow irq enable
		logic [15:0] cnt; // shared counter
		ca_bytes_type mode; // module mode registers
		ca_bytes_type cmp_lo; // compare low bytes
		ca_bytes_type cmp_hi; // compare high bytes
		logic [4:0] pin_out; // module output pins
		logic [4:0] sync1; // capture synchroniser stage 1
		logic [4:0] sync2; // capture synchroniser stage 2
		logic [4:0] prev; // previous synced level
		logic [7:0] div; // timebase divider
		logic irq; // interrupt request
		logic wd_rst; // internal reset pulse
		logic wr_pend; // write data phase pending
		logic [7:0] wr_addr; // latched write offset
		logic [31:0] rdata; // read data
		logic rdy; // hreadyout
		logic resp; // hresp
	} ca_state_type;
endpackage

// >>> rtl/ca_counter_array.sv
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "ca_defines.svh"
module ca_counter_array (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // always okay
	input wire logic [4:0] capture_pin, // async capture inputs
	input wire logic cpu_idle, // cpu in idle mode
	output logic [4:0] module_output_pin, // module outputs
	output logic irq, // shared interrupt
	output logic watchdog_reset // internal reset pulse
);
	ca_pkg::ca_state_type s;
	ca_pkg::ca_state_type n;
	logic tick;
	logic adv;
	logic ovf;
	logic wd_hit;
	logic addr_ok;
	logic [15:0] cnt_inc;
	logic [4:0] match;
	logic [4:0] cap_evt;
	logic [4:0] pwm_act;
	logic [4:0] reload;
	logic [4:0] ev_set;
	logic [4:0] ie_vec;
	logic [31:0] rd;

	// timebase tick and counter advance
	assign tick = (s.div == `CA_TICK_DIV - 8'h01);
	assign adv = tick && s.run && !(s.idle_stop && cpu_idle);
	assign cnt_inc = s.cnt + 16'h0001;
	assign ovf = adv && (s.cnt == 16'hffff);
	assign wd_hit = adv && s.wdog_en
		&& (cnt_inc == {s.cmp_hi[`CA_WDOG_MODULE], s.cmp_lo[`CA_WDOG_MODULE]});
	assign addr_ok = hsel && htrans[1] && hready;

	// per-module event decode
	genvar g;
	generate
		for (g = 0; g < `CA_MODULES; g++) begin : g_mod
			assign pwm_act[g] = s.mode[g][`CA_BIT_PWM] && s.mode[g][`CA_BIT_CMP_EN];
			assign match[g] = adv && s.mode[g][`CA_BIT_CMP_EN]
				&& (cnt_inc == {s.cmp_hi[g], s.cmp_lo[g]});
			assign cap_evt[g] = (s.sync2[g] && !s.prev[g] && s.mode[g][`CA_BIT_CAP_RISE])
				|| (!s.sync2[g] && s.prev[g] && s.mode[g][`CA_BIT_CAP_FALL]);
			assign reload[g] = adv && pwm_act[g] && (s.cnt[7:0] == 8'hff);
			assign ev_set[g] = cap_evt[g] || (match[g] && s.mode[g][`CA_BIT_FLAG_MATCH]);
			// per-module interrupt gate bits, gathered for the checks
			assign ie_vec[g] = s.mode[g][`CA_BIT_MOD_IE];
		end
	endgenerate

	// next state: bus write, then hardware events, then bus address phase
	always_comb begin
		n = s;
		rd = 32'h0000_0000;
		// watchdog pulse lasts one cycle; it never drives the reset pin
		n.wd_rst = wd_hit;
		// two-flop synchroniser, then edge history for the capture pins
		n.sync1 = capture_pin;
		n.sync2 = s.sync1;
		n.prev = s.sync2;
		// free-running timebase divider, independent of the run bit
		n.div = tick ? 8'h00 : s.div + 8'h01;
		// zero wait states and an okay response on every transfer
		n.rdy = 1'b1;
		n.resp = 1'b0;
		// counter step; a software write below overrides the byte it writes
		if (adv) begin
			n.cnt = cnt_inc;
		end
		// software write in data phase
		if (s.wr_pend) begin
			if (s.wr_addr == `CA_OFS_CTRL) begin
				n.run = hwdata[`CA_BIT_RUN];
				n.ovf_flag = s.ovf_flag && hwdata[`CA_BIT_OVF];
				n.ev_flag = s.ev_flag & hwdata[4:0];
			end
			if (s.wr_addr == `CA_OFS_CFG) begin
				n.idle_stop = hwdata[`CA_BIT_IDLE];
				n.wdog_en = hwdata[`CA_BIT_WDOG];
				n.ovf_ie = hwdata[`CA_BIT_OVF_IE];
			end
			if (s.wr_addr == `CA_OFS_CNT_LO) begin
				n.cnt[7:0] = hwdata[7:0];
			end
			if (s.wr_addr == `CA_OFS_CNT_HI) begin
				n.cnt[15:8] = hwdata[7:0];
			end
			for (int i = 0; i < `CA_MODULES; i++) begin
				if (s.wr_addr == `CA_OFS_MODE + 8'(4 * i)) begin
					n.mode[i] = {1'b0, hwdata[6:0]};
				end
				if (s.wr_addr == `CA_OFS_CMP_LO + 8'(4 * i)) begin
					n.cmp_lo[i] = hwdata[7:0];
				end
				if (s.wr_addr == `CA_OFS_CMP_HI + 8'(4 * i)) begin
					n.cmp_hi[i] = hwdata[7:0];
				end
			end
		end
		// hardware sets win over software clears
		if (ovf) begin
			n.ovf_flag = 1'b1;
		end
		n.ev_flag = n.ev_flag | ev_set;
		for (int i = 0; i < `CA_MODULES; i++) begin
			if (cap_evt[i]) begin
				{n.cmp_hi[i], n.cmp_lo[i]} = s.cnt;
			end
			if (reload[i]) begin
				n.cmp_lo[i] = n.cmp_hi[i];
			end
			if (match[i] && s.mode[i][`CA_BIT_TOGGLE]) begin
				n.pin_out[i] = !s.pin_out[i];
			end
			if (pwm_act[i]) begin
				n.pin_out[i] = (n.cnt[7:0] >= n.cmp_lo[i]);
			end
		end
		// shared interrupt
		n.irq = (n.ovf_flag && n.ovf_ie);
		for (int i = 0; i < `CA_MODULES; i++) begin
			n.irq = n.irq || (n.ev_flag[i] && n.mode[i][`CA_BIT_MOD_IE]);
		end
		// address phase: latch writes, fetch reads from updated state
		n.wr_pend = addr_ok && hwrite;
		n.wr_addr = haddr[7:0];
		if (haddr[7:0] == `CA_OFS_CTRL) begin
			rd[7:0] = {n.ovf_flag, n.run, 1'b0, n.ev_flag};
		end
		if (haddr[7:0] == `CA_OFS_CFG) begin
			rd[7:0] = {n.idle_stop, n.wdog_en, 5'h00, n.ovf_ie};
		end
		if (haddr[7:0] == `CA_OFS_CNT_LO) begin
			rd[7:0] = n.cnt[7:0];
		end
		if (haddr[7:0] == `CA_OFS_CNT_HI) begin
			rd[7:0] = n.cnt[15:8];
		end
		for (int i = 0; i < `CA_MODULES; i++) begin
			if (haddr[7:0] == `CA_OFS_MODE + 8'(4 * i)) begin
				rd[7:0] = n.mode[i];
			end
			if (haddr[7:0] == `CA_OFS_CMP_LO + 8'(4 * i)) begin
				rd[7:0] = n.cmp_lo[i];
			end
			if (haddr[7:0] == `CA_OFS_CMP_HI + 8'(4 * i)) begin
				rd[7:0] = n.cmp_hi[i];
			end
		end
		n.rdata = (addr_ok && !hwrite && (haddr[31:8] == 24'h000000)) ? rd : 32'h0000_0000;
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.rdy <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// outputs straight from flops
	assign hreadyout = s.rdy;
	assign hrdata = s.rdata;
	assign hresp = s.resp;
	assign module_output_pin = s.pin_out;
	assign irq = s.irq;
	assign watchdog_reset = s.wd_rst;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_STOPPED_HOLDS: assert property (!s.run && !s.wr_pend |=> s.cnt == $past(s.cnt))
		else $error("counter moved while stopped");
	AST_OVF_FLAG: assert property (adv && s.cnt == 16'hffff && !s.wr_pend
		|=> s.ovf_flag && s.cnt == 16'h0000)
		else $error("overflow flag not set on wrap");
	AST_MATCH_FLAG: assert property (match[0] && s.mode[0][`CA_BIT_FLAG_MATCH] |=> s.ev_flag[0])
		else $error("match did not set module 0 flag");
	AST_IRQ_GATE: assert property (s.ev_flag[0] && s.mode[0][`CA_BIT_MOD_IE] |-> irq)
		else $error("enabled module flag did not raise irq");
	AST_PWM_LEVEL: assert property (pwm_act[2] && $past(pwm_act[2])
		|-> module_output_pin[2] == (s.cnt[7:0] >= s.cmp_lo[2]))
		else $error("pulse-width output level wrong");
	AST_TOGGLE: assert property (match[0] && s.mode[0][`CA_BIT_TOGGLE] && !pwm_act[0]
		|=> module_output_pin[0] != $past(module_output_pin[0]))
		else $error("output did not toggle on match");
	AST_CAPTURE: assert property (cap_evt[1] && !reload[1] |=> {s.cmp_hi[1], s.cmp_lo[1]}
		== $past(s.cnt) && s.ev_flag[1])
		else $error("capture did not load counter");
	AST_RELOAD: assert property (reload[2] && !cap_evt[2] && !s.wr_pend
		|=> s.cmp_lo[2] == $past(s.cmp_hi[2]))
		else $error("compare low not reloaded on rollover");
	AST_WDOG: assert property (s.wdog_en && adv
		&& cnt_inc == {s.cmp_hi[4], s.cmp_lo[4]} |=> watchdog_reset ##1 !watchdog_reset)
		else $error("watchdog reset pulse wrong");
	AST_IDLE_HALT: assert property (s.idle_stop && cpu_idle |-> !adv)
		else $error("counter advanced in idle");

	// the counter takes exactly one step per advance
	AST_RUN_STEP: assert property (
		adv && !s.wr_pend
		|=> s.cnt == $past(cnt_inc))
		else $error("counter did not step by one");

	// without an advance or a write the counter stands still
	AST_HOLD_NO_ADV: assert property (
		!adv && !s.wr_pend
		|=> s.cnt == $past(s.cnt))
		else $error("counter moved without a tick");

	// a cleared run bit blocks every advance
	AST_STOP_NO_ADV: assert property (
		!s.run
		|-> !adv)
		else $error("counter advanced with run bit clear");

	// a tick with the run bit set and no idle stop advances
	AST_RUN_ADV: assert property (
		tick && s.run && !s.idle_stop
		|-> adv)
		else $error("running counter missed a tick");

	// idle stop only matters while the cpu idles
	AST_IDLE_OFF_RUNS: assert property (
		tick && s.run && !cpu_idle
		|-> adv)
		else $error("counter halted outside idle");

	// ticks never come on two cycles in a row
	AST_TICK_SPACING: assert property (
		tick
		|=> !tick)
		else $error("timebase ticked twice in a row");

	// overflow flag stays set until software writes
	AST_OVF_STICKY: assert property (
		s.ovf_flag && !s.wr_pend
		|=> s.ovf_flag)
		else $error("overflow flag dropped by itself");

	// overflow flag rises only on a wrap
	AST_OVF_ONLY_WRAP: assert property (
		!s.ovf_flag && !ovf
		|=> !s.ovf_flag)
		else $error("overflow flag set without a wrap");

	// an enabled overflow flag requests the interrupt
	AST_OVF_IRQ: assert property (
		s.ovf_flag && s.ovf_ie
		|-> irq)
		else $error("overflow did not raise irq");

	// module flags stay set until software writes
	AST_EV_STICKY: assert property (
		!s.wr_pend
		|=> ($past(s.ev_flag) & ~s.ev_flag) == 5'h00)
		else $error("module flag dropped by itself");

	// module flags rise only on a match or a capture
	AST_EV_SOURCE: assert property (
		(s.ev_flag & ~$past(s.ev_flag) & ~$past(ev_set)) == 5'h00)
		else $error("module flag set without an event");

	// the shared interrupt is exactly the enabled flags
	AST_IRQ_LEVEL: assert property (
		irq == ((s.ovf_flag && s.ovf_ie) || (|(s.ev_flag & ie_vec))))
		else $error("shared irq level wrong");

	// without pulse-width mode the pin moves only on a toggle match
	AST_TOG_QUIET: assert property (
		(!match[0] || !s.mode[0][`CA_BIT_TOGGLE]) && !pwm_act[0]
		|=> module_output_pin[0] == $past(module_output_pin[0]))
		else $error("output moved without a toggle match");

	// a comparator that is off leaves the output alone
	AST_PWM_NEEDS_CMP: assert property (
		!s.mode[2][`CA_BIT_CMP_EN]
		|=> module_output_pin[2] == $past(module_output_pin[2]))
		else $error("output moved with comparator off");

	// a match without flag-on-match sets no flag
	AST_NOMAT_NOFLAG: assert property (
		!s.ev_flag[0] && !cap_evt[0] && !(match[0] && s.mode[0][`CA_BIT_FLAG_MATCH])
		|=> !s.ev_flag[0])
		else $error("module 0 flag set without cause");

	// module 4 keeps its ordinary match flag
	AST_MATCH_FLAG4: assert property (
		match[4] && s.mode[4][`CA_BIT_FLAG_MATCH]
		|=> s.ev_flag[4])
		else $error("match did not set module 4 flag");

	// a rising capture needs the rising enable
	AST_CAP_RISE_EN: assert property (
		cap_evt[1] && s.sync2[1]
		|-> s.mode[1][`CA_BIT_CAP_RISE])
		else $error("rising capture while disabled");

	// a falling capture needs the falling enable
	AST_CAP_FALL_EN: assert property (
		cap_evt[1] && !s.sync2[1]
		|-> s.mode[1][`CA_BIT_CAP_FALL])
		else $error("falling capture while disabled");

	// with both enables any transition captures
	AST_CAP_BOTH: assert property (
		s.sync2[1] != s.prev[1] && s.mode[1][`CA_BIT_CAP_RISE] && s.mode[1][`CA_BIT_CAP_FALL]
		|-> cap_evt[1])
		else $error("edge missed with both enables");

	// a capture always sets its module flag
	AST_CAP_FLAG: assert property (
		cap_evt[1]
		|=> s.ev_flag[1])
		else $error("capture did not set module 1 flag");

	// the duty byte changes only at a low-byte rollover, a capture or a bus write
	AST_RELOAD_ONLY_ROLL: assert property (
		pwm_act[2] && !reload[2] && !cap_evt[2] && !s.wr_pend
		|=> s.cmp_lo[2] == $past(s.cmp_lo[2]))
		else $error("duty byte changed mid period");

	// no watchdog pulse while the watchdog is off
	AST_WDOG_OFF: assert property (
		!s.wdog_en
		|=> !watchdog_reset)
		else $error("watchdog pulse while disabled");

	// every watchdog pulse follows a watchdog match
	AST_WDOG_CAUSE: assert property (
		watchdog_reset
		|-> $past(wd_hit))
		else $error("watchdog pulse without a match");

	// main scenarios
	COV_OVERFLOW: cover property (ovf);
	COV_CAPTURE: cover property (cap_evt[1] ##1 s.ev_flag[1]);
	COV_WDOG: cover property (watchdog_reset);
	COV_RELOAD: cover property (reload[2]);
	COV_TOGGLE: cover property (match[0] && s.mode[0][`CA_BIT_TOGGLE]);
endmodule

// >>> tb/ca_pin_model.sv
`timescale 1ns/100ps
// far side of the pins: drives the capture inputs, sees the module outputs
module ca_pin_model (
	input wire logic hclk, // bus clock
	input wire logic [4:0] module_output_pin, // outputs of the block
	output logic [4:0] capture_pin // capture inputs of the block
);
	// pin levels move just after an edge and hold until the next request
	initial capture_pin = 5'h00;
	task put(input logic [4:0] v);
		@(posedge hclk);
		capture_pin <= v;
	endtask
endmodule

// >>> tb/counter_array_capture_pwm_wdog_test.sv
`timescale 1ns/100ps
`include "ca_defines.svh"
module counter_array_capture_pwm_wdog_test;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, cpu_idle = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, w;
	logic hreadyout, hresp, irq, watchdog_reset;
	logic [4:0] capture_pin, module_output_pin;
	int err_count = 0, total_checks = 0, wd_n = 0, w0;
	// clock and watchdog pulse counter
	always #5 hclk = ~hclk;
	always @(posedge hclk) if (watchdog_reset === 1'b1) wd_n <= wd_n + 1;
	ca_counter_array dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .capture_pin(capture_pin),
		.cpu_idle(cpu_idle), .module_output_pin(module_output_pin), .irq(irq),
		.watchdog_reset(watchdog_reset));
	ca_pin_model pm (.hclk(hclk), .module_output_pin(module_output_pin),
		.capture_pin(capture_pin));
	task end_of_test;
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task ck(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task run(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// one bus phase: hold until hready is seen high, data taken at that edge
	task wt(output logic [31:0] d);
		int n;
		logic r;
		n = 0;
		do begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata;
			@(posedge hclk);
			n++;
		end while (r !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			end_of_test;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		wt(w);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wt(w);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		wt(d);
		htrans <= 2'h0;
		wt(d);
	endtask
	task setc(input logic [7:0] lo, input logic [7:0] hi);
		wr(`CA_OFS_CNT_LO, lo);
		wr(`CA_OFS_CNT_HI, hi);
	endtask
	task s_regs;
		rd(`CA_OFS_CTRL, v); ck("ctrl_reset", 32'h0, v);
		wr(`CA_OFS_MODE + 8'h0c, 8'hff);
		rd(`CA_OFS_MODE + 8'h0c, v); ck("mode3", 32'h7f, v);
		rd(8'hfc, v); ck("unmapped", 32'h0, v);
		wr(`CA_OFS_MODE + 8'h0c, 8'h00);
	endtask
	task s_run;
		setc(8'h10, 8'h00);
		wr(`CA_OFS_CTRL, 8'h40);
		run(40);
		wr(`CA_OFS_CTRL, 8'h00);
		rd(`CA_OFS_CNT_LO, v);
		run(20);
		rd(`CA_OFS_CNT_LO, w); ck("cnt_run", 32'h1, {31'h0, v > 32'h10});
		ck("cnt_stop", v, w);
		wr(`CA_OFS_CFG, 8'h80);
		cpu_idle <= 1'b1;
		wr(`CA_OFS_CTRL, 8'h40);
		run(20);
		rd(`CA_OFS_CNT_LO, w); ck("idle_stop", v, w);
		wr(`CA_OFS_CTRL, 8'h00);
		cpu_idle <= 1'b0;
		wr(`CA_OFS_CFG, 8'h00);
	endtask
	task s_ovf;
		wr(`CA_OFS_CFG, 8'h01);
		setc(8'hfe, 8'hff);
		wr(`CA_OFS_CTRL, 8'h40);
		run(20);
		wr(`CA_OFS_CTRL, 8'hbf);
		rd(`CA_OFS_CTRL, v); ck("ovf_flag", 32'h80, v);
		ck("ovf_irq", 32'h1, irq);
		rd(`CA_OFS_CNT_HI, v); ck("wrap", 32'h0, v);
		wr(`CA_OFS_CTRL, 8'h00);
		run(1);
		ck("ovf_clr", 32'h0, irq);
		wr(`CA_OFS_CFG, 8'h00);
	endtask
	task s_match;
		setc(8'h00, 8'h00);
		wr(`CA_OFS_CMP_LO, 8'h20);
		wr(`CA_OFS_CMP_HI, 8'h00);
		wr(`CA_OFS_MODE, 8'h4d);
		wr(`CA_OFS_CTRL, 8'h40);
		run(100);
		wr(`CA_OFS_CTRL, 8'hbf);
		rd(`CA_OFS_CTRL, v); ck("match_flag", 32'h01, v);
		ck("toggle", 32'h1, module_output_pin[0]);
		ck("mod_irq", 32'h1, irq);
		wr(`CA_OFS_MODE, 8'h4c);
		run(1);
		ck("irq_gate", 32'h0, irq);
		wr(`CA_OFS_CTRL, 8'h00);
		wr(`CA_OFS_MODE, 8'h00);
	endtask
	task s_cap;
		setc(8'h34, 8'h12);
		wr(`CA_OFS_MODE + 8'h04, 8'h20);
		wr(`CA_OFS_CTRL, 8'h40);
		pm.put(5'h02);
		run(10);
		wr(`CA_OFS_CTRL, 8'hbf);
		rd(`CA_OFS_CMP_HI + 8'h04, v); ck("cap_hi", 32'h12, v);
		rd(`CA_OFS_CTRL, v); ck("cap_rise", 32'h02, v);
		wr(`CA_OFS_CTRL, 8'h00);
		pm.put(5'h00);
		run(10);
		rd(`CA_OFS_CTRL, v); ck("no_fall", 32'h0, v);
		wr(`CA_OFS_MODE + 8'h04, 8'h10);
		pm.put(5'h02);
		pm.put(5'h00);
		run(10);
		rd(`CA_OFS_CTRL, v); ck("cap_fall", 32'h02, v);
		wr(`CA_OFS_CTRL, 8'h00);
		wr(`CA_OFS_MODE + 8'h04, 8'h30);
		pm.put(5'h02);
		run(10);
		rd(`CA_OFS_CTRL, v); ck("cap_both_rise", 32'h02, v);
		wr(`CA_OFS_CTRL, 8'h00);
		pm.put(5'h00);
		run(10);
		rd(`CA_OFS_CTRL, v); ck("cap_both_fall", 32'h02, v);
		wr(`CA_OFS_CTRL, 8'h00);
		wr(`CA_OFS_MODE + 8'h04, 8'h00);
	endtask
	task s_wd;
		w0 = wd_n;
		wr(`CA_OFS_CFG, 8'h40);
		wr(`CA_OFS_CMP_LO + 8'h10, 8'h10);
		wr(`CA_OFS_CMP_HI + 8'h10, 8'h00);
		setc(8'h00, 8'h00);
		wr(`CA_OFS_CTRL, 8'h40);
		run(60);
		wr(`CA_OFS_CTRL, 8'h00);
		ck("wd_pulse", 32'h1, wd_n - w0);
		setc(8'h00, 8'h00);
		wr(`CA_OFS_CMP_LO + 8'h10, 8'h18);
		wr(`CA_OFS_CTRL, 8'h40);
		run(20);
		wr(`CA_OFS_CMP_LO + 8'h10, 8'h40);
		run(20);
		wr(`CA_OFS_CMP_LO + 8'h10, 8'h60);
		run(20);
		wr(`CA_OFS_CTRL, 8'h00);
		ck("wd_held", 32'h1, wd_n - w0);
		wr(`CA_OFS_CMP_LO + 8'h10, 8'h10);
		wr(`CA_OFS_CFG, 8'h00);
		wr(`CA_OFS_MODE + 8'h10, 8'h48);
		setc(8'h00, 8'h00);
		wr(`CA_OFS_CTRL, 8'h40);
		run(60);
		wr(`CA_OFS_CTRL, 8'hbf);
		ck("wd_off", 32'h1, wd_n - w0);
		rd(`CA_OFS_CTRL, v); ck("mod4_flag", 32'h10, v);
		wr(`CA_OFS_CTRL, 8'h00);
		wr(`CA_OFS_MODE + 8'h10, 8'h00);
	endtask
	task s_pwm;
		setc(8'hf0, 8'h00);
		wr(`CA_OFS_CMP_LO + 8'h08, 8'h00);
		wr(`CA_OFS_CMP_HI + 8'h08, 8'h80);
		wr(`CA_OFS_MODE + 8'h08, 8'h42);
		repeat (2) begin
			wr(`CA_OFS_CTRL, 8'h40);
			run(200);
			wr(`CA_OFS_CTRL, 8'h00);
			rd(`CA_OFS_CMP_LO + 8'h08, v); ck("reload", 32'h80, v);
			rd(`CA_OFS_CNT_LO, w);
			ck("pwm_out", {31'h0, w >= 32'h80}, module_output_pin[2]);
		end
	endtask
	initial begin
		run(4);
		hresetn <= 1'b1;
		run(1);
		s_regs;
		s_run;
		s_ovf;
		s_match;
		s_cap;
		s_wd;
		s_pwm;
		end_of_test;
	end
endmodule
